/* File: hdl/cthl_pkg.sv */
package cthl_pkg;
  // ===========================================================
  // register byte addresses
  localparam logic [7:0] CTHL_CFG_ADDR  = 8'h00;
  localparam logic [7:0] CTHL_STS_ADDR  = 8'h04;
  localparam logic [7:0] CTHL_PTR_ADDR  = 8'h08;
  localparam logic [7:0] CTHL_ACC0_ADDR = 8'h0c;
  localparam logic [7:0] CTHL_ACC1_ADDR = 8'h10;
  localparam logic [7:0] CTHL_GCTL_ADDR = 8'h14;
  // ===========================================================
  // field positions
  localparam int CTHL_CFG_LOG_EN   = 0;
  localparam int CTHL_CFG_IRQ_EN   = 1;
  localparam int CTHL_CFG_IRQ_MODE = 2;
  localparam int CTHL_STS_EMPTY    = 0;
  localparam int CTHL_STS_OVF      = 1;
  localparam int CTHL_STS_IRQ      = 2;
  localparam int CTHL_STS_CNT_LSB  = 8;
  localparam int CTHL_GCTL_OVF_IE  = 0;
  localparam int CTHL_ACC_IDX_LSB  = 8;
  localparam int CTHL_ACC_LBL_LSB  = 16;
  // ===========================================================
  // field widths and codes
  localparam int CTHL_KIND_W  = 3;
  localparam int CTHL_DEPTH   = 64;
  localparam int CTHL_IDX_W   = 7;
  localparam int CTHL_LBL_W   = 8;
  localparam int CTHL_TS_W    = 16;
  localparam logic [2:0] CTHL_KIND_TXBUF = 3'h1;
  localparam logic [2:0] CTHL_KIND_FIFO  = 3'h2;
  localparam logic [2:0] CTHL_KIND_QUEUE = 3'h4;
  localparam logic [7:0] CTHL_PTR_ADVANCE = 8'hff;
  localparam logic [31:0] CTHL_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] CTHL_GCTL_RST = 32'h0000_0000;
  // threshold numerator and denominator of the fill interrupt
  localparam int CTHL_THR_NUM = 3;
  localparam int CTHL_THR_DEN = 4;
endpackage : cthl_pkg

/* File: hdl/cthl_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module cthl_mem #(
  parameter int W     = 34,
  parameter int DEPTH = 64,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          pclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata_r
);
  logic [W-1:0] store [DEPTH];

  always_ff @(posedge pclk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
    rdata_r <= store[raddr];
  end
endmodule : cthl_mem
`default_nettype wire

/* File: hdl/cthl_flag.sv */
`timescale 1ns/100ps
`default_nettype none
// sticky flag: a set in the clearing cycle wins
module cthl_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_r
);
  logic flag_nxt;

  assign flag_nxt = set | (flag_r & ~clr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
endmodule : cthl_flag
`default_nettype wire

/* File: hdl/cthl_log.sv */
`timescale 1ns/100ps
`default_nettype none
// How it works
// - one log per channel, 64 entries
// - store entry only on successful transmission
// - kind codes 001 buffer, 010 fifo, 100 queue
// - index names the sending buffer or fifo
// - entry keeps label and time stamp
// - software picks per message whether logged
// - log needs log enable and request bit
// - irq at three quarters, or every entry
// - irq request gated by own enable
// - history irq merged into transmit line
// - log disable keeps irq flag; write zero
// - write ff to pointer field advances
// - sticky overflow flag, cleared writing zero
// - overflow raises global error when enabled
// - overflow enable is one global bit
module cthl_log
  import cthl_pkg::*;
#(
  parameter int DEPTH = CTHL_DEPTH,
  parameter int IDX_W = CTHL_IDX_W,
  parameter int LBL_W = CTHL_LBL_W,
  parameter int TS_W  = CTHL_TS_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             tx_done,
  input  wire logic [2:0]       tx_buf_kind,
  input  wire logic [IDX_W-1:0] tx_buf_index,
  input  wire logic [LBL_W-1:0] tx_label,
  input  wire logic [TS_W-1:0]  tx_timestamp,
  input  wire logic             msg_log_request,
  input  wire logic             tx_irq_other,
  output logic                  hist_irq,
  output logic                  tx_irq,
  output logic                  global_err_irq
);
  localparam int AW  = $clog2(DEPTH);
  localparam int CW  = AW + 1;
  localparam int EW  = CTHL_KIND_W + IDX_W + LBL_W + TS_W;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] THR_CNT  =
    CW'((DEPTH * CTHL_THR_NUM) / CTHL_THR_DEN);

  // ===========================================================
  // parameter checks
  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("cthl_log: DEPTH must be a power of two, at least 4");
  end
  if (IDX_W > 8 || LBL_W > 16 || TS_W > 32 || IDX_W < 1) begin : g_bad_w
    $error("cthl_log: field widths do not fit the access window");
  end

  // ===========================================================
  // bus decode
  logic bus_wr;
  logic bus_rd;
  logic sel_cfg;
  logic sel_sts;
  logic sel_ptr;
  logic sel_acc0;
  logic sel_acc1;
  logic sel_gctl;
  logic mapped;

  assign bus_wr   = psel & penable & pwrite;
  assign bus_rd   = psel & penable & ~pwrite;
  assign sel_cfg  = (paddr == CTHL_CFG_ADDR);
  assign sel_sts  = (paddr == CTHL_STS_ADDR);
  assign sel_ptr  = (paddr == CTHL_PTR_ADDR);
  assign sel_acc0 = (paddr == CTHL_ACC0_ADDR);
  assign sel_acc1 = (paddr == CTHL_ACC1_ADDR);
  assign sel_gctl = (paddr == CTHL_GCTL_ADDR);
  assign mapped   = sel_cfg | sel_sts | sel_ptr | sel_acc0 | sel_acc1
                  | sel_gctl;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  // ===========================================================
  // control registers
  logic log_enable_r;
  logic irq_enable_r;
  logic irq_mode_r;
  logic ovf_irq_enable_r;
  logic cfg_wr;
  logic gctl_wr;

  assign cfg_wr  = bus_wr & sel_cfg;
  assign gctl_wr = bus_wr & sel_gctl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_enable_r <= CTHL_CFG_RST[CTHL_CFG_LOG_EN];
      irq_enable_r <= CTHL_CFG_RST[CTHL_CFG_IRQ_EN];
      irq_mode_r   <= CTHL_CFG_RST[CTHL_CFG_IRQ_MODE];
    end else if (cfg_wr) begin
      // mode discipline on this bit is left to software
      log_enable_r <= pwdata[CTHL_CFG_LOG_EN];
      irq_enable_r <= pwdata[CTHL_CFG_IRQ_EN];
      irq_mode_r   <= pwdata[CTHL_CFG_IRQ_MODE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_irq_enable_r <= CTHL_GCTL_RST[CTHL_GCTL_OVF_IE];
    end else if (gctl_wr) begin
      ovf_irq_enable_r <= pwdata[CTHL_GCTL_OVF_IE];
    end
  end

  // ===========================================================
  // entry capture and pointers
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic          empty;
  logic          full;
  logic          log_req;
  logic          store_en;
  logic          overflow;
  logic          advance;
  logic [EW-1:0] entry_in;
  logic [EW-1:0] entry_out;

  assign empty    = (count_r == '0);
  assign full     = (count_r == FULL_CNT);
  // only successful, enabled, requested messages are logged
  assign log_req  = tx_done & log_enable_r & msg_log_request;
  assign store_en = log_req & ~full;
  assign overflow = log_req & full;
  // device guards the pointer as software is asked to
  assign advance  = bus_wr & sel_ptr
                  & (pwdata[7:0] == CTHL_PTR_ADVANCE)
                  & log_enable_r & ~empty;
  assign entry_in = {tx_buf_kind, tx_buf_index, tx_label,
                     tx_timestamp};

  always_comb begin
    count_nxt = count_r;
    if (store_en && !advance) begin
      count_nxt = count_r + CW'(1);
    end else if (advance && !store_en) begin
      count_nxt = count_r - CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (store_en) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (advance) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      count_r <= count_nxt;
    end
  end

  cthl_mem #(
    .W     (EW),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .pclk    (pclk),
    .we      (store_en),
    .waddr   (wr_ptr_r),
    .wdata   (entry_in),
    .raddr   (rd_ptr_r),
    .rdata_r (entry_out)
  );

  // ===========================================================
  // status flags
  logic irq_set;
  logic irq_clr;
  logic ovf_clr;
  logic irq_flag_r;
  logic ovf_flag_r;
  logic thr_hit;

  assign thr_hit = (count_nxt >= THR_CNT);
  assign irq_set = store_en & (irq_mode_r | thr_hit);
  // disabling the log leaves the flag alone
  assign irq_clr = bus_wr & sel_sts & ~pwdata[CTHL_STS_IRQ];
  assign ovf_clr = bus_wr & sel_sts & ~pwdata[CTHL_STS_OVF];

  cthl_flag u_irq_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (irq_set),
    .clr     (irq_clr),
    .flag_r  (irq_flag_r)
  );

  cthl_flag u_ovf_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (overflow),
    .clr     (ovf_clr),
    .flag_r  (ovf_flag_r)
  );

  // ===========================================================
  // interrupt outputs
  assign hist_irq       = irq_flag_r & irq_enable_r;
  assign tx_irq         = hist_irq | tx_irq_other;
  assign global_err_irq = ovf_flag_r & ovf_irq_enable_r;

  // ===========================================================
  // read data
  logic [31:0] cfg_word;
  logic [31:0] sts_word;
  logic [31:0] acc0_word;
  logic [31:0] acc1_word;
  logic [31:0] gctl_word;
  logic [2:0]  out_kind;
  logic [IDX_W-1:0] out_idx;
  logic [LBL_W-1:0] out_lbl;
  logic [TS_W-1:0]  out_ts;

  assign {out_kind, out_idx, out_lbl, out_ts} = entry_out;

  always_comb begin
    cfg_word  = '0;
    sts_word  = '0;
    acc0_word = '0;
    acc1_word = '0;
    gctl_word = '0;
    cfg_word[CTHL_CFG_LOG_EN]   = log_enable_r;
    cfg_word[CTHL_CFG_IRQ_EN]   = irq_enable_r;
    cfg_word[CTHL_CFG_IRQ_MODE] = irq_mode_r;
    sts_word[CTHL_STS_EMPTY]    = empty;
    sts_word[CTHL_STS_OVF]      = ovf_flag_r;
    sts_word[CTHL_STS_IRQ]      = irq_flag_r;
    sts_word[CTHL_STS_CNT_LSB +: CW] = count_r;
    acc0_word[CTHL_KIND_W-1:0]  = out_kind;
    acc0_word[CTHL_ACC_IDX_LSB +: IDX_W] = out_idx;
    acc0_word[CTHL_ACC_LBL_LSB +: LBL_W] = out_lbl;
    acc1_word[TS_W-1:0]         = out_ts;
    gctl_word[CTHL_GCTL_OVF_IE] = ovf_irq_enable_r;
  end

  assign prdata = !bus_rd  ? 32'h0000_0000 :
                  sel_cfg  ? cfg_word  :
                  sel_sts  ? sts_word  :
                  sel_acc0 ? acc0_word :
                  sel_acc1 ? acc1_word :
                  sel_gctl ? gctl_word : 32'h0000_0000;
endmodule : cthl_log
`default_nettype wire

/* File: test/cthl_tx_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========
// transmit scheduler: one success pulse per sent frame
module cthl_tx_model (
  input  wire logic pclk,
  output logic        tx_done,
  output logic [2:0]  kind,
  output logic [6:0]  idx,
  output logic [7:0]  lbl,
  output logic [15:0] ts,
  output logic        req
);
  initial {tx_done, kind, idx, lbl, ts, req} = '0;
  task automatic send(input logic [33:0] x, input logic r);
    @(posedge pclk);
    tx_done <= 1'b1;
    {kind, idx, lbl, ts} <= x;
    req <= r;
    @(posedge pclk);
    tx_done <= 1'b0;
    {kind, idx, lbl, ts} <= ~x;
    req <= ~r;
  endtask : send
endmodule : cthl_tx_model
`default_nettype wire

/* File: test/cthl_log_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module cthl_log_checker
  import cthl_pkg::*;
#(
  parameter int DEPTH = CTHL_DEPTH
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        tx_done,
  input wire logic        msg_log_request,
  input wire logic        tx_irq_other,
  input wire logic        hist_irq,
  input wire logic        tx_irq,
  input wire logic        global_err_irq
);
  // ==========
  // shadow of configuration and fill level
  logic       wr, sts_wr, st, adv, log_r, ien_r, mode_r, oie_r;
  logic [6:0] cnt_r;
  assign wr = psel & penable & pwrite;
  assign sts_wr = wr & (paddr == CTHL_STS_ADDR);
  assign st = tx_done & msg_log_request & log_r & (cnt_r != 7'(DEPTH));
  assign adv = wr & (paddr == CTHL_PTR_ADDR) & (pwdata[7:0] == 8'hff)
             & log_r & (cnt_r != 7'h00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {mode_r, ien_r, log_r, oie_r} <= '0;
      cnt_r <= '0;
    end else begin
      if (wr && paddr == CTHL_CFG_ADDR) {mode_r, ien_r, log_r} <= pwdata[2:0];
      if (wr && paddr == CTHL_GCTL_ADDR) oie_r <= pwdata[0];
      cnt_r <= cnt_r + 7'(st) - 7'(adv);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_line_merge: assert property (tx_irq == (hist_irq | tx_irq_other))
    else $error("transmit line not merged");
  a_irq_gated: assert property (hist_irq |-> ien_r)
    else $error("irq without enable");
  a_every_entry: assert property (st && ien_r && mode_r && !wr |=> hist_irq)
    else $error("no irq after stored entry");
  a_fill_level: assert property (st && ien_r && !mode_r && !wr
    && cnt_r == 7'(DEPTH * 3 / 4 - 1) |=> hist_irq)
    else $error("no irq at fill level");
  a_no_req_quiet: assert property (tx_done && !(msg_log_request && log_r)
    && !wr |=> $stable(hist_irq) && $stable(global_err_irq))
    else $error("unlogged frame changed flags");
  a_irq_sticky: assert property (hist_irq && !(sts_wr && !pwdata[2])
    && !(wr && paddr == CTHL_CFG_ADDR && !pwdata[1]) |=> hist_irq)
    else $error("irq flag lost");
  a_ovf_at_full: assert property (tx_done && msg_log_request && log_r
    && cnt_r == 7'(DEPTH) && oie_r && !wr |=> global_err_irq)
    else $error("overflow not raised");
  a_ovf_global: assert property (global_err_irq |-> oie_r)
    else $error("error irq without enable");
  a_ovf_sticky: assert property ($fell(global_err_irq) |-> $past(wr))
    else $error("overflow flag fell alone");
  cover property (st && mode_r);
  cover property ($rose(global_err_irq));
  cover property (cnt_r == 7'(DEPTH));
endmodule : cthl_log_checker
bind cthl_log cthl_log_checker #(.DEPTH(DEPTH)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tx_done(tx_done),
  .msg_log_request(msg_log_request), .tx_irq_other(tx_irq_other),
  .hist_irq(hist_irq), .tx_irq(tx_irq), .global_err_irq(global_err_irq));
`default_nettype wire

/* File: test/cthl_log_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module cthl_log_tb;
  import cthl_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic        pready, pslverr, e, oth = 0, done, req, hirq, tirq, gerr;
  logic [2:0]  kind;
  logic [6:0]  idx;
  logic [7:0]  lbl;
  logic [15:0] ts;
  int          n_errors = 0, total_checks = 0;
  always #50 pclk = ~pclk;
  cthl_log i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_done(done),
    .tx_buf_kind(kind), .tx_buf_index(idx), .tx_label(lbl),
    .tx_timestamp(ts), .msg_log_request(req), .tx_irq_other(oth),
    .hist_irq(hirq), .tx_irq(tirq), .global_err_irq(gerr));
  cthl_tx_model i_tx (.pclk(pclk), .tx_done(done), .kind(kind), .idx(idx),
    .lbl(lbl), .ts(ts), .req(req));
  // ==========
  // bus and compare helpers
  function automatic logic [33:0] ent(input int k);
    return {3'(1 << (k % 3)), 7'(k + 1), 8'(8'ha0 + k), 16'(16'h1230 + k)};
  endfunction : ent
  function automatic logic [31:0] w0(input logic [33:0] x);
    return {8'h0, x[23:16], 1'b0, x[30:24], 5'h0, x[33:31]};
  endfunction : w0
  function automatic logic [31:0] sts(input int c, input logic o, i);
    return {17'h0, 7'(c), 5'h0, i, o, c == 0};
  endfunction : sts
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // answer and read data are taken at the edge that samples pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(q, x);
  endtask : rd
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  // ==========
  // scenarios
  task automatic t_regs;
    rd(CTHL_CFG_ADDR, CTHL_CFG_RST);
    chk({31'h0, e}, 0);
    rd(CTHL_GCTL_ADDR, CTHL_GCTL_RST);
    rd(CTHL_STS_ADDR, sts(0, 0, 0));
    rd(8'h40, 0);
    chk({31'h0, e}, 1);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_fifo;
    logic [33:0] x;
    apb(1, CTHL_CFG_ADDR, 32'h1);
    for (int k = 0; k < 3; k++) i_tx.send(ent(k), 1);
    rd(CTHL_STS_ADDR, sts(3, 0, 0));
    apb(1, CTHL_PTR_ADDR, 32'hfe);
    for (int k = 0; k < 3; k++) begin
      x = ent(k);
      rd(CTHL_ACC0_ADDR, w0(x));
      rd(CTHL_ACC1_ADDR, {16'h0, x[15:0]});
      apb(1, CTHL_PTR_ADDR, 32'hff);
    end
    rd(CTHL_STS_ADDR, sts(0, 0, 0));
    i_tx.send(ent(5), 0);
    apb(1, CTHL_CFG_ADDR, 0);
    i_tx.send(ent(6), 1);
    rd(CTHL_STS_ADDR, sts(0, 0, 0));
    $display("t_fifo done");
  endtask : t_fifo
  task automatic t_irq;
    apb(1, CTHL_CFG_ADDR, 32'h7);
    i_tx.send(ent(7), 1);
    @(negedge pclk);
    chk({30'h0, hirq, tirq}, 3);
    apb(1, CTHL_CFG_ADDR, 32'h4);
    @(negedge pclk);
    chk({31'h0, hirq}, 0);
    rd(CTHL_STS_ADDR, sts(1, 0, 1));
    oth <= 1;
    apb(1, CTHL_CFG_ADDR, 32'h7);
    apb(1, CTHL_STS_ADDR, 0);
    @(negedge pclk);
    chk({30'h0, hirq, tirq}, 1);
    oth <= 0;
    apb(1, CTHL_PTR_ADDR, 32'hff);
    rd(CTHL_STS_ADDR, sts(0, 0, 0));
    $display("t_irq done");
  endtask : t_irq
  task automatic t_fill;
    apb(1, CTHL_CFG_ADDR, 32'h3);
    apb(1, CTHL_GCTL_ADDR, 32'h1);
    for (int k = 0; k < 47; k++) i_tx.send(ent(k), 1);
    @(negedge pclk);
    chk({31'h0, hirq}, 0);
    for (int k = 47; k < 65; k++) i_tx.send(ent(k), 1);
    @(negedge pclk);
    chk({30'h0, hirq, gerr}, 3);
    rd(CTHL_STS_ADDR, sts(64, 1, 1));
    rd(CTHL_ACC0_ADDR, w0(ent(0)));
    apb(1, CTHL_STS_ADDR, 0);
    rd(CTHL_STS_ADDR, sts(64, 0, 0));
    for (int k = 0; k < 64; k++) apb(1, CTHL_PTR_ADDR, 32'hff);
    rd(CTHL_STS_ADDR, sts(0, 0, 0));
    $display("t_fill done");
  endtask : t_fill
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_fifo;
    t_irq;
    t_fill;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    end_sim;
  end
endmodule : cthl_log_tb
`default_nettype wire
